// *** shared/ptm_params.svh ***
// Constant definitions for the paired timer block.
`ifndef PTM_PARAMS_SVH
`define PTM_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PTM_OFS_LOW_CTRL 12'h000
`define PTM_OFS_HIGH_CTRL 12'h004
`define PTM_OFS_PERIOD_LOW 12'h008
`define PTM_OFS_PERIOD_HIGH 12'h00C
`define PTM_OFS_COUNT_LOW 12'h010
`define PTM_OFS_COUNT_HIGH 12'h014
`define PTM_OFS_STATUS 12'h018
`define PTM_OFS_SYSCTL 12'h01C
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PTM_BIT_RUN 15
`define PTM_BIT_IDLE_STOP 13
`define PTM_BIT_GATED 6
`define PTM_BIT_PS_HI 5
`define PTM_BIT_PS_LO 4
`define PTM_BIT_JOIN 3
`define PTM_BIT_CLKSRC 1
`define PTM_CTRL_MASK 16'hA07A
`define PTM_CTRL_RESET 16'h0000
`define PTM_PERIOD_RESET 16'hFFFF
// ----------------------------------------
// Status and system control fields
// ----------------------------------------
`define PTM_BIT_FLAG_LOW 0
`define PTM_BIT_FLAG_HIGH 1
`define PTM_BIT_IDLE 0
`define PTM_BIT_IE 1
`define PTM_PRIO_LO 4
`define PTM_PRIO_HI 6
`endif

// *** shared/ptm_pkg.sv ***
// Types shared by the paired timer block.
package ptm_pkg;
  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gated_accumulate;
    logic [1:0] prescale_select;
    logic pair_join;
    logic clock_source_select;
  } ptm_ctrl_t;

  typedef enum logic [1:0] {
    PTM_DIV1 = 2'b00,
    PTM_DIV8 = 2'b01,
    PTM_DIV64 = 2'b10,
    PTM_DIV256 = 2'b11
  } ptm_div_t;

  typedef enum logic [1:0] {
    PTM_BUS_IDLE = 2'b00,
    PTM_BUS_DATA = 2'b01
  } ptm_bus_t;

  typedef struct packed {
    logic write;
    logic [11:0] addr;
  } ptm_req_t;
endpackage

// *** hw/ptm_prescaler.sv ***
// Tick prescaler with clock source select and gate qualification.
`timescale 1ns/100ps
module ptm_prescaler #(
  parameter int PS_W = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic active,
  input wire ptm_pkg::ptm_ctrl_t ctrl,
  input wire logic ext_clock_pin,
  input wire logic gate_pin,
  output logic tick,
  output logic gate_fall
);
  logic ext_reg;
  logic gate_reg;
  logic [PS_W-1:0] ps_reg;
  logic [PS_W-1:0] ps_next;
  logic [PS_W-1:0] ps_top;
  logic src_edge;
  logic gating;
  logic qual;

  // Only the internal clock can be gated; with the pin selected the gate bit is ignored.
  assign gating = ctrl.gated_accumulate & ~ctrl.clock_source_select;
  // External source counts rising edges of the pin, internal counts every cycle.
  assign src_edge = ctrl.clock_source_select ? (ext_clock_pin & ~ext_reg) : 1'b1;
  assign qual = active & src_edge & (~gating | gate_pin);
  assign ps_top = (ctrl.prescale_select == ptm_pkg::PTM_DIV1) ? PS_W'(0) :
                  (ctrl.prescale_select == ptm_pkg::PTM_DIV8) ? PS_W'(7) :
                  (ctrl.prescale_select == ptm_pkg::PTM_DIV64) ? PS_W'(63) :
                  PS_W'(255);
  assign ps_next = !active ? '0 : !qual ? ps_reg : (ps_reg >= ps_top) ? '0 : ps_reg + 1'b1;
  assign tick = qual & (ps_reg >= ps_top);
  assign gate_fall = active & gating & gate_reg & ~gate_pin;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ext_reg <= 1'b0;
      gate_reg <= 1'b0;
      ps_reg <= '0;
    end else begin
      ext_reg <= ext_clock_pin;
      gate_reg <= gate_pin;
      ps_reg <= ps_next;
    end
  end

  div8_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ctrl.prescale_select == 2'b01 && qual && ps_reg == 0 && !tick) |-> ##1 ps_reg == 1)
    else $error("prescaler did not advance");
  ext_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl.clock_source_select |-> !gate_fall)
    else $error("gate acted with external clock");
endmodule

// *** hw/ptm_counter.sv ***
// One 16-bit counter half with period match.
`timescale 1ns/100ps
module ptm_counter #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic inc,
  input wire logic clear,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] period,
  output logic [W-1:0] count,
  output logic at_period
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  assign at_period = (count_reg == period);
  // The count goes to zero only when clear is set, not on a match by itself; load wins over clear.
  assign count_next = load ? load_val : clear ? '0 : inc ? count_reg + 1'b1 : count_reg;
  assign count = count_reg;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  wrap_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clear && !load) |=> count_reg == 0)
    else $error("counter did not wrap");
endmodule

// *** hw/ptm_timer_pair.sv ***
// Paired 16/32-bit timer with AHB-Lite register access.
// Functional notes
// - Pair runs as one 32-bit timer or two separate 16-bit timers.
// - Split halves are synchronous 16-bit; joined gives 32-bit timer or counter.
// - Joined, low timer holds low count word, high timer the upper word.
// - Joined, high control register is ignored; low control drives everything.
// - Joined, low clock and gate are used; match raises high timer flag.
// - Joined, flag rises when full 32-bit count equals 32-bit period.
// - Period high register is upper word, period low the lower word.
// - Joined, count registers read as high and low words of the 32-bit count.
// - Join bit 3 of low control selects 32-bit operation when set.
// - Run bit 15 starts the timer on one and stops it on zero.
// - Joined timer runs in Idle only when idle-stop is cleared.
// - Clock source bit selects external pin on one, internal clock on zero.
// - Only the first pair gives capture/compare time base and DMA requests.
// - First pair triggers the first ADC, second pair the second ADC.
`timescale 1ns/100ps
`include "ptm_params.svh"
module ptm_timer_pair #(
  parameter int PAIR_INDEX = 0,
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic idle_mode,
  input wire logic ext_clock_pin_low,
  input wire logic ext_clock_pin_high,
  input wire logic gate_pin_low,
  input wire logic gate_pin_high,
  output logic irq_low,
  output logic irq_high,
  output logic [2:0] pair_irq_priority,
  output logic adc1_trigger,
  output logic adc2_trigger,
  output logic dma_request,
  output logic [W-1:0] capture_time_base_low,
  output logic [W-1:0] capture_time_base_high
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  ptm_pkg::ptm_ctrl_t low_ctrl_reg;
  ptm_pkg::ptm_ctrl_t high_ctrl_reg;
  ptm_pkg::ptm_ctrl_t ctrl_eff_high;
  ptm_pkg::ptm_req_t req_reg;
  ptm_pkg::ptm_bus_t bus_reg;
  logic [W-1:0] period_low_reg;
  logic [W-1:0] period_high_reg;
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic irq_enable_reg;
  logic [2:0] prio_reg;
  logic [31:0] hrdata_reg;
  logic trig_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic [31:0] ctrl_word(input ptm_pkg::ptm_ctrl_t c);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`PTM_BIT_RUN] = c.run;
    v[`PTM_BIT_IDLE_STOP] = c.idle_stop;
    v[`PTM_BIT_GATED] = c.gated_accumulate;
    v[`PTM_BIT_PS_HI:`PTM_BIT_PS_LO] = c.prescale_select;
    v[`PTM_BIT_JOIN] = c.pair_join;
    v[`PTM_BIT_CLKSRC] = c.clock_source_select;
    return v;
  endfunction

  function automatic ptm_pkg::ptm_ctrl_t word_ctrl(input logic [31:0] v, input logic join_ok);
    ptm_pkg::ptm_ctrl_t c;
    c.run = v[`PTM_BIT_RUN];
    c.idle_stop = v[`PTM_BIT_IDLE_STOP];
    c.gated_accumulate = v[`PTM_BIT_GATED];
    c.prescale_select = v[`PTM_BIT_PS_HI:`PTM_BIT_PS_LO];
    c.pair_join = v[`PTM_BIT_JOIN] & join_ok;
    c.clock_source_select = v[`PTM_BIT_CLKSRC];
    return c;
  endfunction

  logic addr_phase;
  logic wr_data;
  logic rd_sel;
  logic [31:0] rd_word;
  logic [11:0] rd_addr;
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_data = (bus_reg == ptm_pkg::PTM_BUS_DATA) & req_reg.write;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // ----------------------------------------
  // Counting datapath
  // ----------------------------------------
  logic joined;
  logic active_low;
  logic active_high;
  logic tick_low;
  logic tick_high;
  logic fall_low;
  logic fall_high;
  logic [W-1:0] cnt_low;
  logic [W-1:0] cnt_high;
  logic match_low;
  logic match_high;
  logic match32;
  logic inc_low;
  logic inc_high;
  logic clr_low;
  logic clr_high;
  logic ld_low;
  logic ld_high;
  logic ev_low;
  logic ev_high;

  assign joined = low_ctrl_reg.pair_join;
  // Joined, the high half takes no notice of its own control word.
  assign ctrl_eff_high = joined ? low_ctrl_reg : high_ctrl_reg;
  assign active_low = low_ctrl_reg.run & ~(idle_mode & low_ctrl_reg.idle_stop);
  assign active_high = high_ctrl_reg.run & ~(idle_mode & high_ctrl_reg.idle_stop);

  ptm_prescaler #(.PS_W(8)) u_ps_low (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .active(active_low),
    .ctrl(low_ctrl_reg),
    .ext_clock_pin(ext_clock_pin_low),
    .gate_pin(gate_pin_low),
    .tick(tick_low),
    .gate_fall(fall_low)
  );

  ptm_prescaler #(.PS_W(8)) u_ps_high (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .active(active_high & ~joined),
    .ctrl(ctrl_eff_high),
    .ext_clock_pin(ext_clock_pin_high),
    .gate_pin(gate_pin_high),
    .tick(tick_high),
    .gate_fall(fall_high)
  );

  assign match32 = match_low & match_high;
  // Joined: low word counts every tick and carries into the high word.
  assign inc_low = tick_low;
  assign inc_high = joined ? (tick_low & (cnt_low == {W{1'b1}}) & ~match32) : tick_high;
  assign clr_low = joined ? (tick_low & match32) : (tick_low & match_low);
  assign clr_high = joined ? (tick_low & match32) : (tick_high & match_high);
  assign ld_low = wr_data & (req_reg.addr == `PTM_OFS_COUNT_LOW);
  assign ld_high = wr_data & (req_reg.addr == `PTM_OFS_COUNT_HIGH);
  assign ev_low = ~joined & (clr_low | fall_low);
  // Joined match events go to the high flag only.
  assign ev_high = joined ? (clr_high | fall_low) : (clr_high | fall_high);

  ptm_counter #(.W(W)) u_cnt_low (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .inc(inc_low),
    .clear(clr_low),
    .load(ld_low),
    .load_val(hwdata[W-1:0]),
    .period(period_low_reg),
    .count(cnt_low),
    .at_period(match_low)
  );

  ptm_counter #(.W(W)) u_cnt_high (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .inc(inc_high),
    .clear(clr_high),
    .load(ld_high),
    .load_val(hwdata[W-1:0]),
    .period(period_high_reg),
    .count(cnt_high),
    .at_period(match_high)
  );

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  // A read whose address phase overlaps a write to the same register returns the old value.
  assign rd_addr = {haddr[11:2], 2'b00};
  assign rd_word = (rd_addr == `PTM_OFS_LOW_CTRL) ? ctrl_word(low_ctrl_reg) :
                   (rd_addr == `PTM_OFS_HIGH_CTRL) ? ctrl_word(high_ctrl_reg) :
                   (rd_addr == `PTM_OFS_PERIOD_LOW) ? {16'h0000, period_low_reg} :
                   (rd_addr == `PTM_OFS_PERIOD_HIGH) ? {16'h0000, period_high_reg} :
                   (rd_addr == `PTM_OFS_COUNT_LOW) ? {16'h0000, cnt_low} :
                   (rd_addr == `PTM_OFS_COUNT_HIGH) ? {16'h0000, cnt_high} :
                   (rd_addr == `PTM_OFS_STATUS) ? {30'h0000_0000, flag_reg} :
                   (rd_addr == `PTM_OFS_SYSCTL) ?
                     {25'h000_0000, prio_reg, 2'b00, irq_enable_reg, 1'b0} :
                   32'h0000_0000;
  assign rd_sel = addr_phase & ~hwrite;

  // Hardware set wins over a software clear in the same cycle.
  assign flag_next = ((wr_data && req_reg.addr == `PTM_OFS_STATUS) ?
                      (flag_reg & ~hwdata[1:0]) : flag_reg) | {ev_high, ev_low};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      low_ctrl_reg <= '0;
      high_ctrl_reg <= '0;
      period_low_reg <= `PTM_PERIOD_RESET;
      period_high_reg <= `PTM_PERIOD_RESET;
      flag_reg <= 2'b00;
      irq_enable_reg <= 1'b0;
      prio_reg <= 3'b000;
      bus_reg <= ptm_pkg::PTM_BUS_IDLE;
      req_reg <= '0;
      hrdata_reg <= 32'h0000_0000;
      trig_reg <= 1'b0;
    end else begin
      bus_reg <= addr_phase ? ptm_pkg::PTM_BUS_DATA : ptm_pkg::PTM_BUS_IDLE;
      if (addr_phase) begin
        req_reg <= '{write: hwrite, addr: {haddr[11:2], 2'b00}};
      end
      // Captured at the address phase so that the word stands through the data phase.
      if (rd_sel) begin
        hrdata_reg <= rd_word;
      end
      flag_reg <= flag_next;
      trig_reg <= joined ? clr_high : clr_low;
      if (wr_data) begin
        unique case (req_reg.addr)
          `PTM_OFS_LOW_CTRL: low_ctrl_reg <= word_ctrl(hwdata, 1'b1);
          `PTM_OFS_HIGH_CTRL: high_ctrl_reg <= word_ctrl(hwdata, 1'b0);
          `PTM_OFS_PERIOD_LOW: period_low_reg <= hwdata[W-1:0];
          `PTM_OFS_PERIOD_HIGH: period_high_reg <= hwdata[W-1:0];
          `PTM_OFS_SYSCTL: begin
            irq_enable_reg <= hwdata[`PTM_BIT_IE];
            prio_reg <= hwdata[`PTM_PRIO_HI:`PTM_PRIO_LO];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs to interrupt controller, ADC, DMA and capture units
  // ----------------------------------------
  assign irq_low = irq_enable_reg & flag_reg[`PTM_BIT_FLAG_LOW];
  assign irq_high = irq_enable_reg & flag_reg[`PTM_BIT_FLAG_HIGH];
  assign pair_irq_priority = prio_reg;
  // The pulses come from flops so the consumers see a clean single cycle.
  assign adc1_trigger = (PAIR_INDEX == 0) & trig_reg;
  assign adc2_trigger = (PAIR_INDEX == 1) & trig_reg;
  assign dma_request = (PAIR_INDEX == 0) & trig_reg;
  assign capture_time_base_low = (PAIR_INDEX == 0) ? cnt_low : '0;
  assign capture_time_base_high = (PAIR_INDEX == 0) ? cnt_high : '0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_match32;
    joined && tick_low && match32;
  endsequence

  wrap32_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_match32 and !ld_low and !ld_high |=> cnt_low == 0 && cnt_high == 0 && flag_reg[1])
    else $error("32-bit match did not wrap and flag");
  joined_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    joined && $past(joined) && !$past(flag_reg[0]) |-> !flag_reg[0])
    else $error("joined pair set low flag");
  stopped_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!low_ctrl_reg.run && !ld_low) |=> $stable(cnt_low))
    else $error("stopped timer counted");
  idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (idle_mode && low_ctrl_reg.idle_stop && !ld_low) |=> $stable(cnt_low))
    else $error("timer ran in idle");
  carry_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (joined && tick_low && cnt_low == 16'hFFFF && !match32 && !ld_low && !ld_high)
    |=> cnt_low == 0 && cnt_high == $past(cnt_high) + 1'b1)
    else $error("carry into high word lost");
  unimpl_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (bus_reg == ptm_pkg::PTM_BUS_DATA && !req_reg.write &&
    req_reg.addr == `PTM_OFS_LOW_CTRL) |-> (hrdata & ~32'h0000_A07A) == 0)
    else $error("unimplemented bit read nonzero");
  high_ignored_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    joined |-> !tick_high && ctrl_eff_high == low_ctrl_reg)
    else $error("high control used while joined");
  adc_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    adc1_trigger |-> PAIR_INDEX == 0 && $past(clr_high || clr_low))
    else $error("stray ADC trigger");
endmodule

// *** testbench/tb.sv ***
// Self-checking testbench for the paired timer block.
`timescale 1ns/100ps
`include "ptm_params.svh"
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {
    logic is_reg;
    logic [31:0] val;
  } ptm_note_t;
  localparam logic [15:0] RUN = 16'h8000;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic idle_mode = 1'b0;
  logic ext_clock_pin_low = 1'b0;
  logic ext_clock_pin_high = 1'b0;
  logic gate_pin_low = 1'b0;
  logic gate_pin_high = 1'b0;
  logic ext_on = 1'b0;
  logic [1:0] ext_div = 2'h0;
  logic [7:0] seed = 8'h5E;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq_low;
  logic irq_high;
  logic [2:0] pair_irq_priority;
  logic adc1_trigger;
  logic adc2_trigger;
  logic dma_request;
  logic [15:0] capture_time_base_low;
  logic [15:0] capture_time_base_high;
  ptm_note_t exp_q[$];
  logic [31:0] obs_q[$];
  int fails = 0;
  int samples_checked = 0;
  int divs[4] = '{1, 8, 64, 256};

  assign hready = hreadyout;

  ptm_timer_pair #(.PAIR_INDEX(0), .W(16)) i_ptm_timer_pair (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .idle_mode(idle_mode),
    .ext_clock_pin_low(ext_clock_pin_low), .ext_clock_pin_high(ext_clock_pin_high),
    .gate_pin_low(gate_pin_low), .gate_pin_high(gate_pin_high),
    .irq_low(irq_low), .irq_high(irq_high), .pair_irq_priority(pair_irq_priority),
    .adc1_trigger(adc1_trigger), .adc2_trigger(adc2_trigger),
    .dma_request(dma_request), .capture_time_base_low(capture_time_base_low),
    .capture_time_base_high(capture_time_base_high)
  );

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Pin stimulus
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // The high half pins carry noise, so a joined pair that listens to them is caught.
  always @(posedge ref_clk) begin
    seed <= lfsr(seed);
    gate_pin_high <= seed[0];
    ext_clock_pin_high <= seed[1];
    if (ext_on) begin
      ext_div <= ext_div + 2'h1;
      if (ext_div == 2'h3) begin
        ext_clock_pin_low <= ~ext_clock_pin_low;
      end
    end
  end

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] o);
    samples_checked++;
    if (o !== e) begin
      fails++;
      $display("Error at %0t: register read %h, expected %h", $time, o, e);
    end
  endtask

  task automatic cmp_pin(input logic [31:0] e, input logic [31:0] o);
    samples_checked++;
    if (o !== e) begin
      fails++;
      $display("Error at %0t: pin value %h, expected %h", $time, o, e);
    end
  endtask

  task automatic note(input logic is_reg, input logic [31:0] e, input logic [31:0] o);
    exp_q.push_back('{is_reg, e});
    obs_q.push_back(o);
  endtask

  initial begin
    ptm_note_t n;
    logic [31:0] o;
    forever begin
      wait (obs_q.size() != 0);
      n = exp_q.pop_front();
      o = obs_q.pop_front();
      if (n.is_reg) begin
        cmp_reg(n.val, o);
      end else begin
        cmp_pin(n.val, o);
      end
    end
  end

  // ----------------------------------------
  // Bus and timer tasks
  // ----------------------------------------
  task automatic xfer(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr_en;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    note(1'b1, e, q);
  endtask

  task automatic setup(input logic [15:0] ctl, input logic [15:0] hctl,
                       input logic [31:0] per, input logic [31:0] cnt);
    wr(`PTM_OFS_LOW_CTRL, {16'h0000, ctl & ~RUN});
    wr(`PTM_OFS_HIGH_CTRL, {16'h0000, hctl});
    wr(`PTM_OFS_STATUS, 32'h0000_0003);
    wr(`PTM_OFS_COUNT_LOW, {16'h0000, cnt[15:0]});
    wr(`PTM_OFS_COUNT_HIGH, {16'h0000, cnt[31:16]});
    wr(`PTM_OFS_PERIOD_LOW, {16'h0000, per[15:0]});
    wr(`PTM_OFS_PERIOD_HIGH, {16'h0000, per[31:16]});
    wr(`PTM_OFS_LOW_CTRL, {16'h0000, ctl});
  endtask

  // Measures the cycles between two trigger pulses, which is one full period.
  task automatic gap_chk(input int exp_gap);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (adc1_trigger !== 1'b1) @(negedge ref_clk);
    do begin
      @(negedge ref_clk);
      n++;
    end while (adc1_trigger !== 1'b1);
    note(1'b0, 32'(exp_gap), 32'(n));
    note(1'b0, 32'h0000_0001, {30'h0, adc2_trigger, dma_request});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [15:0] v;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd_chk(12'(4 * i), (i == 2 || i == 3) ? 32'h0000_FFFF : 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, seed[6:0], lfsr(seed)};
      wr(`PTM_OFS_LOW_CTRL, {16'h0000, v});
      rd_chk(`PTM_OFS_LOW_CTRL, {16'h0000, v & `PTM_CTRL_MASK});
    end
    wr(`PTM_OFS_SYSCTL, 32'h0000_0052);
    @(negedge ref_clk);
    note(1'b0, 32'h0000_0005, {29'h0, pair_irq_priority});
    for (int ps = 0; ps < 4; ps++) begin
      setup(RUN | {10'h000, 2'(ps), 4'h0}, 16'h0000, 32'h0000_0002, 32'h0000_0000);
      gap_chk(3 * divs[ps]);
    end
    note(1'b0, 32'h0000_0001, {30'h0, irq_high, irq_low});
    wr(`PTM_OFS_LOW_CTRL, 32'h0000_0000);
    rd_chk(`PTM_OFS_STATUS, 32'h0000_0001);
    wr(`PTM_OFS_STATUS, 32'h0000_0001);
    rd_chk(`PTM_OFS_STATUS, 32'h0000_0000);
    // A stopping timer in Idle must not move at all.
    idle_mode <= 1'b1;
    setup(RUN | 16'h2000, 16'h0000, 32'h0000_0004, 32'h0000_0000);
    repeat (20) @(posedge ref_clk);
    note(1'b0, 32'h0000_0000, {16'h0000, capture_time_base_low});
    idle_mode <= 1'b0;
    gap_chk(5);
    ext_on <= 1'b1;
    setup(RUN | 16'h0042, 16'h0000, 32'h0000_0003, 32'h0000_0000);
    gap_chk(32);
    ext_on <= 1'b0;
    setup(RUN | 16'h0040, 16'h0000, 32'h0000_FFFF, 32'h0000_0000);
    repeat (20) @(posedge ref_clk);
    note(1'b0, 32'h0000_0000, {16'h0000, capture_time_base_low});
    gate_pin_low <= 1'b1;
    repeat (10) @(posedge ref_clk);
    gate_pin_low <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd_chk(`PTM_OFS_STATUS, 32'h0000_0001);
    rd_chk(`PTM_OFS_COUNT_LOW, 32'h0000_000A);
    // Joined pair in Idle; the high control asks for stop and a slow clock, both ignored.
    idle_mode <= 1'b1;
    setup(RUN | 16'h0008, 16'hA030, 32'h0001_0001, 32'h0000_FFFE);
    gap_chk(65538);
    note(1'b0, 32'h0000_0002, {30'h0, irq_high, irq_low});
    note(1'b0, 32'h0000_0000, {16'h0000, capture_time_base_high});
    wr(`PTM_OFS_LOW_CTRL, 32'h0000_0008);
    idle_mode <= 1'b0;
    rd_chk(`PTM_OFS_STATUS, 32'h0000_0002);
    rd_chk(`PTM_OFS_COUNT_HIGH, 32'h0000_0000);
    wait (obs_q.size() == 0);
    conclude();
  end

  // The scenarios need about 68000 cycles, the joined period being most of them.
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    conclude();
  end
endmodule
